// [logic/flash_cmd_defines.vh]
// Offsets, field positions and timing counts of the flash command front end
// Included by the register block only; the command slot store does not use it
`ifndef FLASH_CMD_DEFINES_VH
`define FLASH_CMD_DEFINES_VH

// Printed register indices (byte address is four times the index)
`define IDX_CONFIG        8'h04
`define IDX_STATUS        8'h06
`define IDX_ERR_STATUS    8'h07
`define IDX_PFLASH_PROT   8'h08
`define IDX_EEE_PROT      8'h09
`define IDX_CMD_OBJ_HI    8'h0a
`define IDX_CMD_OBJ_LO    8'h0b
`define IDX_TAG_HI        8'h0c
`define IDX_TAG_LO        8'h0d
`define IDX_ECC_HI        8'h0e
`define IDX_ECC_LO        8'h0f
`define IDX_NV_OPTIONS    8'h10
`define IDX_RSV_ZERO      8'h11
`define IDX_RSV_ONE       8'h12
`define IDX_RSV_TWO       8'h13
`define IDX_CMD_INDEX     8'h01
`define IDX_ECC_INDEX     8'h02

// Configuration fields
`define CFG_DONE_IE       7
`define CFG_SF_IGNORE     4
`define CFG_FORCE_DF      1
`define CFG_FORCE_SF      0
`define CFG_MASK          8'h93

// Status fields
`define ST_DONE           7
`define ST_ACCESS_ERROR_FLAG         5
`define ST_PVIOL          4
`define ERR_DFD           1
`define ERR_SFD           0

// Command codes and slot figures
`define CMD_LOAD_FIELD    8'h05
`define CMD_PROGRAM       8'h06
`define LOAD_LAST_SLOT    3'h5
`define GLOBAL_ADDR_MAX   23'h7fffff
`define PROGRAM_TIME_NS   200
`define CLK_PERIOD_NS     10
`define PROGRAM_CYCLES    (`PROGRAM_TIME_NS / `CLK_PERIOD_NS)

// Reset values
`define RESET_STATUS      8'h80
`define RESET_PROT        8'hff

`endif

// [logic/cmd_slot_store.v]
// Eight 16-bit command object slots with registered read data
// Assumes single-port writes from the register block on the same clock
module cmd_slot_store #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // Write port
    input  wire             wr_en_i,
    input  wire [AW-1:0]    wr_addr_i,
    input  wire [WIDTH-1:0] wr_data_i,
    // Read port
    input  wire [AW-1:0]    rd_addr_i,
    output reg  [WIDTH-1:0] rd_data_o
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    integer         k;

    always @(posedge clk_i) begin
        if (rst_i) begin
            for (k = 0; k < DEPTH; k = k + 1) begin
                mem[k] <= {WIDTH{1'b0}};
            end
            rd_data_o <= {WIDTH{1'b0}};
        end else begin
            if (wr_en_i) begin
                mem[wr_addr_i] <= wr_data_i;
            end
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule

// [logic/flash_command_config_regs.v]
// Register front end of the flash controller over AXI4-Lite
// Assumes one clock; ECC faults and tags come from the array side, options from NV_OPTIONS
`include "flash_cmd_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Three test reserved registers read zero, ignore writes
// - Config enables done interrupt and fault forcing
// - Only four config bits writable, rest zero
// - Done interrupt raised when enabled and done set
// - Ignore bit suppresses single fault reporting
// - Three-bit index selects ECC result word
// - Load launch checks index, alignment, address
// - Clearing done launches; done sets when complete
// - Other command or error cancels load sequence
module flash_command_config_regs #(
    parameter PROGRAM_CYCLES = `PROGRAM_CYCLES,
    parameter [7:0] NV_OPTIONS = 8'hff
) (
    // Clock and reset
    input  wire        SYS_CLK_I,
    input  wire        RST_I,
    // AXI4-Lite write channels
    input  wire [31:0] AWADDR_I,
    input  wire        AWVALID_I,
    output reg         AWREADY_O,
    input  wire [31:0] WDATA_I,
    input  wire [3:0]  WSTRB_I,
    input  wire        WVALID_I,
    output reg         WREADY_O,
    output reg  [1:0]  BRESP_O,
    output reg         BVALID_O,
    input  wire        BREADY_I,
    // AXI4-Lite read channels
    input  wire [31:0] ARADDR_I,
    input  wire        ARVALID_I,
    output reg         ARREADY_O,
    output reg  [31:0] RDATA_O,
    output reg  [1:0]  RRESP_O,
    output reg         RVALID_O,
    input  wire        RREADY_I,
    // Array side events
    input  wire        SINGLE_FAULT_I,
    input  wire        DOUBLE_FAULT_I,
    input  wire [15:0] ECC_WORD_I,
    input  wire [15:0] TAG_COUNT_I,
    // Fault forcing, interrupt and load activity
    output reg         FORCE_SINGLE_O,
    output reg         FORCE_DOUBLE_O,
    output reg         CMD_DONE_IRQ_O,
    output reg         LOAD_ACTIVE_O
);

    function [7:0] word_index;
        input [31:0] addr;
        begin
            word_index = addr[9:2];
        end
    endfunction

    localparam ST_IDLE = 2'b00;
    localparam ST_BUSY = 2'b01;

    reg  [7:0]  flash_config;
    reg  [7:0]  flash_error_status;
    reg         cmd_done_flag;
    reg         access_error_flag;
    reg         protection_violation_flag;
    reg  [7:0]  pflash_prot;
    reg  [7:0]  eee_prot;
    reg  [2:0]  command_object_index;
    reg  [2:0]  ecc_word_select;
    reg  [15:0] ecc_result_array [0:7];
    reg  [2:0]  ecc_fill;
    reg  [15:0] slot_hold;
    reg  [1:0]  state;
    reg  [15:0] busy_count;
    reg         load_active;
    reg         aw_got;
    reg         w_got;
    reg  [31:0] aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg  [15:0] slot0;
    reg  [15:0] slot1;
    wire [15:0] slot_rd;
    wire        wr_go;
    wire [7:0]  wr_idx;
    wire [7:0]  wr_byte;
    wire        launch;
    wire [7:0]  cmd_code;
    wire [22:0] global_addr;
    wire        load_bad;
    reg  [7:0]  rd_byte;
    reg         rd_ok;
    integer     j;

    function lane0_on;
        input [3:0] s;
        begin
            lane0_on = s[0];
        end
    endfunction
    assign wr_go   = aw_got && w_got && !BVALID_O;
    assign wr_idx  = word_index(aw_addr);
    assign wr_byte = lane0_on(w_strb) ? w_data[7:0] : 8'h00;

    // Writing a one to the done flag clears it and starts the loaded command; a load failing its checks sets the access error instead
    assign launch  = wr_go && w_strb[0] && wr_idx == `IDX_STATUS &&
                     w_data[`ST_DONE] && cmd_done_flag;
    assign cmd_code    = slot0[15:8];
    assign global_addr = {slot0[6:0], slot1};
    assign load_bad    = command_object_index != `LOAD_LAST_SLOT ||
                         slot1[2:0] != 3'b000 ||
                         global_addr > `GLOBAL_ADDR_MAX;

    cmd_slot_store #(
        .WIDTH (16),
        .DEPTH (8),
        .AW    (3)
    ) u_slots (
        .clk_i     (SYS_CLK_I),
        .rst_i     (RST_I),
        .wr_en_i   (wr_go && (wr_idx == `IDX_CMD_OBJ_HI || wr_idx == `IDX_CMD_OBJ_LO)
                    && w_strb[0] && cmd_done_flag),
        .wr_addr_i (command_object_index),
        .wr_data_i (slot_hold),
        .rd_addr_i (command_object_index),
        .rd_data_o (slot_rd)
    );

    always @* begin
        slot_hold = slot_rd;
        if (wr_idx == `IDX_CMD_OBJ_HI) begin
            slot_hold = {w_data[7:0], slot_rd[7:0]};
        end else begin
            slot_hold = {slot_rd[15:8], w_data[7:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write path
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            AWREADY_O <= 1'b0;
            WREADY_O  <= 1'b0;
            BVALID_O  <= 1'b0;
            BRESP_O   <= 2'b00;
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            aw_addr   <= 32'h0;
            w_data    <= 32'h0;
            w_strb    <= 4'h0;
        end else begin
            AWREADY_O <= !aw_got && !AWREADY_O && AWVALID_I && !BVALID_O;
            WREADY_O  <= !w_got && !WREADY_O && WVALID_I && !BVALID_O;
            if (AWVALID_I && AWREADY_O) begin
                aw_got  <= 1'b1;
                aw_addr <= AWADDR_I;
            end
            if (WVALID_I && WREADY_O) begin
                w_got  <= 1'b1;
                w_data <= WDATA_I;
                w_strb <= WSTRB_I;
            end
            if (wr_go) begin
                BVALID_O <= 1'b1;
                BRESP_O  <= (wr_idx >= `IDX_CONFIG && wr_idx <= `IDX_RSV_TWO) ||
                            wr_idx == `IDX_CMD_INDEX || wr_idx == `IDX_ECC_INDEX
                            ? 2'b00 : 2'b10;
                aw_got   <= 1'b0;
                w_got    <= 1'b0;
            end else if (BVALID_O && BREADY_I) begin
                BVALID_O <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            flash_config         <= 8'h00;
            pflash_prot          <= `RESET_PROT;
            eee_prot             <= `RESET_PROT;
            command_object_index <= 3'h0;
            ecc_word_select      <= 3'h0;
            slot0                <= 16'h0;
            slot1                <= 16'h0;
        end else if (wr_go && w_strb[0]) begin
            case (wr_idx)
                `IDX_CONFIG:      flash_config <= wr_byte & `CFG_MASK;
                `IDX_PFLASH_PROT: pflash_prot  <= wr_byte;
                `IDX_EEE_PROT:    eee_prot     <= wr_byte;
                `IDX_CMD_INDEX:   command_object_index <= w_data[2:0];
                `IDX_ECC_INDEX:   ecc_word_select <= w_data[2:0];
                `IDX_CMD_OBJ_HI, `IDX_CMD_OBJ_LO: begin
                    if (cmd_done_flag && command_object_index == 3'h0) begin
                        slot0 <= slot_hold;
                    end
                    if (cmd_done_flag && command_object_index == 3'h1) begin
                        slot1 <= slot_hold;
                    end
                end
                // Reserved test registers swallow writes
                default: flash_config <= flash_config;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencer
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state                     <= ST_IDLE;
            cmd_done_flag             <= 1'b1;
            access_error_flag         <= 1'b0;
            protection_violation_flag <= 1'b0;
            busy_count                <= 16'h0;
            load_active               <= 1'b0;
        end else begin
            if (wr_go && w_strb[0] && wr_idx == `IDX_STATUS) begin
                if (w_data[`ST_ACCESS_ERROR_FLAG]) access_error_flag <= 1'b0;
                if (w_data[`ST_PVIOL])  protection_violation_flag <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (launch) begin
                        if (cmd_code == `CMD_LOAD_FIELD && load_bad) begin
                            access_error_flag <= 1'b1;
                            load_active       <= 1'b0;
                        end else if (cmd_code == `CMD_LOAD_FIELD) begin
                            cmd_done_flag <= 1'b0;
                            load_active   <= 1'b1;
                            busy_count    <= PROGRAM_CYCLES[15:0];
                            state         <= ST_BUSY;
                        end else begin
                            if (cmd_code != `CMD_PROGRAM) begin
                                load_active <= 1'b0;
                            end
                            cmd_done_flag <= 1'b0;
                            busy_count    <= PROGRAM_CYCLES[15:0];
                            state         <= ST_BUSY;
                        end
                    end
                end
                ST_BUSY: begin
                    if (busy_count <= 16'h1) begin
                        cmd_done_flag <= 1'b1;
                        if (cmd_code == `CMD_PROGRAM) begin
                            load_active <= 1'b0;
                        end
                        state <= ST_IDLE;
                    end else begin
                        busy_count <= busy_count - 16'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error status and ECC results
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            flash_error_status <= 8'h00;
            ecc_fill           <= 3'h0;
            for (j = 0; j < 8; j = j + 1) begin
                ecc_result_array[j] <= 16'h0;
            end
        end else begin
            if (wr_go && w_strb[0] && wr_idx == `IDX_ERR_STATUS) begin
                flash_error_status <= flash_error_status & ~(w_data[7:0] & 8'h03);
            end
            if (DOUBLE_FAULT_I || FORCE_DOUBLE_O) begin
                flash_error_status[`ERR_DFD] <= 1'b1;
            end
            if ((SINGLE_FAULT_I || FORCE_SINGLE_O) && !flash_config[`CFG_SF_IGNORE]) begin
                flash_error_status[`ERR_SFD] <= 1'b1;
            end
            if (DOUBLE_FAULT_I || ((SINGLE_FAULT_I || FORCE_SINGLE_O) &&
                !flash_config[`CFG_SF_IGNORE])) begin
                ecc_result_array[ecc_fill] <= ECC_WORD_I;
                ecc_fill <= ecc_fill + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    always @* begin
        rd_ok   = 1'b1;
        rd_byte = 8'h00;
        case (word_index(ARADDR_I))
            `IDX_CONFIG:      rd_byte = flash_config;
            `IDX_STATUS:      rd_byte = {cmd_done_flag, 1'b0, access_error_flag,
                                         protection_violation_flag, 4'h0};
            `IDX_ERR_STATUS:  rd_byte = flash_error_status;
            `IDX_PFLASH_PROT: rd_byte = pflash_prot;
            `IDX_EEE_PROT:    rd_byte = eee_prot;
            `IDX_CMD_OBJ_HI:  rd_byte = slot_rd[15:8];
            `IDX_CMD_OBJ_LO:  rd_byte = slot_rd[7:0];
            `IDX_TAG_HI:      rd_byte = TAG_COUNT_I[15:8];
            `IDX_TAG_LO:      rd_byte = TAG_COUNT_I[7:0];
            `IDX_ECC_HI:      rd_byte = ecc_result_array[ecc_word_select][15:8];
            `IDX_ECC_LO:      rd_byte = ecc_result_array[ecc_word_select][7:0];
            `IDX_NV_OPTIONS:  rd_byte = NV_OPTIONS;
            `IDX_RSV_ZERO, `IDX_RSV_ONE, `IDX_RSV_TWO: rd_byte = 8'h00;
            `IDX_CMD_INDEX:   rd_byte = {5'h00, command_object_index};
            `IDX_ECC_INDEX:   rd_byte = {5'h00, ecc_word_select};
            default:          rd_ok   = 1'b0;
        endcase
    end

    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            ARREADY_O <= 1'b0;
            RVALID_O  <= 1'b0;
            RDATA_O   <= 32'h0;
            RRESP_O   <= 2'b00;
        end else begin
            ARREADY_O <= ARVALID_I && !ARREADY_O && !RVALID_O;
            if (ARVALID_I && ARREADY_O) begin
                RVALID_O <= 1'b1;
                RDATA_O  <= {24'h0, rd_byte};
                RRESP_O  <= rd_ok ? 2'b00 : 2'b10;
            end else if (RVALID_O && RREADY_I) begin
                RVALID_O <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            FORCE_SINGLE_O <= 1'b0;
            FORCE_DOUBLE_O <= 1'b0;
            CMD_DONE_IRQ_O <= 1'b0;
            LOAD_ACTIVE_O  <= 1'b0;
        end else begin
            FORCE_SINGLE_O <= flash_config[`CFG_FORCE_SF];
            FORCE_DOUBLE_O <= flash_config[`CFG_FORCE_DF];
            CMD_DONE_IRQ_O <= flash_config[`CFG_DONE_IE] && cmd_done_flag;
            LOAD_ACTIVE_O  <= load_active;
        end
    end

endmodule

// [verif/flash_cfg_properties.sv]
// Checker of the flash register front end, bound to its top module
// Assumes byte address four times the register index, one write and one read at a time
module flash_cfg_checker (
    // Clock and reset
    input logic        SYS_CLK_I,
    input logic        RST_I,
    // Register bus
    input logic [31:0] AWADDR_I,
    input logic        AWVALID_I,
    input logic        AWREADY_O,
    input logic [31:0] WDATA_I,
    input logic [3:0]  WSTRB_I,
    input logic        WVALID_I,
    input logic        WREADY_O,
    input logic [1:0]  BRESP_O,
    input logic        BVALID_O,
    input logic        BREADY_I,
    input logic [31:0] ARADDR_I,
    input logic        ARVALID_I,
    input logic        ARREADY_O,
    input logic [31:0] RDATA_O,
    input logic [1:0]  RRESP_O,
    input logic        RVALID_O,
    input logic        RREADY_I,
    // Fault forcing, interrupt and load activity
    input logic        FORCE_SINGLE_O,
    input logic        FORCE_DOUBLE_O,
    input logic        CMD_DONE_IRQ_O,
    input logic        LOAD_ACTIVE_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] waddr;
    logic [31:0] raddr;
    logic [7:0]  wd;
    wire         cfg_b  = BVALID_O && BREADY_I && waddr == 32'h10;
    wire         rd_hit = RVALID_O && RREADY_I;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    ////////////////////////////////////////////////////////////////////////////////
    // Last taken addresses and data
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            waddr <= 32'h0;
            raddr <= 32'h0;
            wd    <= 8'h0;
        end else begin
            if (AWVALID_I && AWREADY_O) waddr <= AWADDR_I;
            if (WVALID_I && WREADY_O && WSTRB_I[0]) wd <= WDATA_I[7:0];
            if (ARVALID_I && ARREADY_O) raddr <= ARADDR_I;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_rsv_read_zero: assert property (
        rd_hit && raddr inside {32'h44, 32'h48, 32'h4c} |-> RDATA_O == 32'h0)
        else $error("reserved register read nonzero");
    a_cfg_read_mask: assert property (
        rd_hit && raddr == 32'h10 |-> (RDATA_O & ~32'h93) == 32'h0)
        else $error("config unused bits nonzero");
    a_force_follows_cfg: assert property (
        cfg_b |=> FORCE_SINGLE_O == wd[0] && FORCE_DOUBLE_O == wd[1])
        else $error("fault forcing outputs differ from config");
    a_irq_off_disabled: assert property (
        cfg_b && !wd[7] |=> !CMD_DONE_IRQ_O)
        else $error("interrupt with enable clear");
    a_b_holds: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
        else $error("write response dropped");
    a_r_holds: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
        else $error("read data dropped");
    a_aw_ready_pulse: assert property (AWREADY_O |=> !AWREADY_O)
        else $error("address ready longer than one cycle");
    a_b_after_w: assert property (
        AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O)
        else $error("write response late");
    a_r_after_ar: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
        else $error("read data late");
    a_unmapped_err: assert property (
        rd_hit && raddr > 32'h4c |-> RRESP_O == 2'b10 && RDATA_O == 32'h0)
        else $error("unmapped read not refused");
    c_irq: cover property ($rose(CMD_DONE_IRQ_O));
    c_load: cover property ($rose(LOAD_ACTIVE_O));
    c_slverr: cover property (BVALID_O && BREADY_I && BRESP_O == 2'b10);
endmodule

bind flash_command_config_regs flash_cfg_checker u_chk (
    .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I),
    .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I),
    .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
    .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
    .FORCE_SINGLE_O(FORCE_SINGLE_O), .FORCE_DOUBLE_O(FORCE_DOUBLE_O),
    .CMD_DONE_IRQ_O(CMD_DONE_IRQ_O), .LOAD_ACTIVE_O(LOAD_ACTIVE_O));

// [verif/axil_host.sv]
// Register bus master standing for host software
// Assumes an AXI4-Lite slave on the same clock; waits without limit
module axil_host (
    // Clock
    input  logic        clk_i,
    // Write channels
    output logic [31:0] awaddr_o,
    output logic        awvalid_o,
    input  logic        awready_i,
    output logic [31:0] wdata_o,
    output logic [3:0]  wstrb_o,
    output logic        wvalid_o,
    input  logic        wready_i,
    input  logic [1:0]  bresp_i,
    input  logic        bvalid_i,
    output logic        bready_o,
    // Read channels
    output logic [31:0] araddr_o,
    output logic        arvalid_o,
    input  logic        arready_i,
    input  logic [31:0] rdata_i,
    input  logic [1:0]  rresp_i,
    input  logic        rvalid_i,
    output logic        rready_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int stall = 0;
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
        wstrb_o = 4'hf;
    end
    // Released lines show the inverse so a late capture is seen
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw;
        logic w;
        @(posedge clk_i);
        awaddr_o  <= a;
        wdata_o   <= d;
        awvalid_o <= 1'b1;
        wvalid_o  <= 1'b1;
        aw = 1'b0;
        w  = 1'b0;
        while (!(aw && w)) begin
            @(posedge clk_i);
            if (!aw && awready_i) begin
                aw = 1'b1;
                awvalid_o <= 1'b0;
                awaddr_o  <= ~a;
            end
            if (!w && wready_i) begin
                w = 1'b1;
                wvalid_o <= 1'b0;
                wdata_o  <= ~d;
            end
        end
        repeat (stall) @(posedge clk_i);
        bready_o <= 1'b1;
        do @(posedge clk_i); while (!bvalid_i);
        r = bresp_i;
        bready_o <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr_o  <= a;
        arvalid_o <= 1'b1;
        do @(posedge clk_i); while (!arready_i);
        arvalid_o <= 1'b0;
        araddr_o  <= ~a;
        repeat (stall) @(posedge clk_i);
        rready_o <= 1'b1;
        do @(posedge clk_i); while (!rvalid_i);
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
    endtask
endmodule

// [verif/tb.sv]
// Self-checking bench of the flash register front end
// Assumes the design answers every bus request; a cycle ceiling ends a hang
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin err_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, a); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PC = 20;
    logic        clk = 1'b0, rst = 1'b1, sf = 1'b0, df = 1'b0;
    logic [15:0] eccw = 16'h0, tag = 16'h0;
    logic [31:0] awaddr, wdata, araddr, rdata, ed;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, er;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, fs, fd, irq, lact;
    int          err_count = 0, n_checks = 0, cyc = 0, seed, esum = 0;
    int          mdl[int];
    int          wa[$] = '{'h10, 'h20, 'h24, 'h08, 'h04, 'h44, 'h48, 'h4c};
    flash_command_config_regs #(.PROGRAM_CYCLES(PC)) u_dut (
        .SYS_CLK_I(clk), .RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
        .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
        .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
        .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
        .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .SINGLE_FAULT_I(sf),
        .DOUBLE_FAULT_I(df), .ECC_WORD_I(eccw), .TAG_COUNT_I(tag), .FORCE_SINGLE_O(fs),
        .FORCE_DOUBLE_O(fd), .CMD_DONE_IRQ_O(irq), .LOAD_ACTIVE_O(lact));
    axil_host u_host (
        .clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
        .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
        .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
        .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
        .rvalid_i(rvalid), .rready_o(rready));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Bus access with register model update and compare
    task automatic wm(input int a, input int d);
        logic [1:0] b;
        u_host.stall = $urandom_range(2, 0);
        u_host.wr(a, d, b);
        `CHK("bresp", mdl.exists(a) ? 2'b00 : 2'b10, b)
        case (a)
            'h10: mdl[a] = d & 'h93;
            'h04, 'h08: mdl[a] = d & 7;
            'h20, 'h24, 'h28, 'h2c: mdl[a] = d & 'hff;
            'h18: mdl[a] &= ~(d & 'h30);
            'h1c: mdl[a] &= ~d;
            default: ;
        endcase
    endtask
    task automatic rdc(input int a);
        logic [31:0] d;
        logic [1:0]  rr;
        u_host.stall = $urandom_range(2, 0);
        u_host.rd(a, d, rr);
        `CHK("rdata", mdl.exists(a) ? mdl[a] : 0, d)
        `CHK("rresp", mdl.exists(a) ? 2'b00 : 2'b10, rr)
    endtask
    task automatic pulse(input logic s, input logic dd);
        @(posedge clk);
        sf   <= s;
        df   <= dd;
        eccw <= $urandom;
        @(posedge clk);
        sf <= 1'b0;
        df <= 1'b0;
    endtask
    task automatic load(input int code, input int ix, input int lo);
        for (int i = 0; i < 6; i++) begin
            wm('h04, i);
            wm('h28, i == 0 ? code : $urandom_range(255, 0));
            wm('h2c, i == 1 ? lo : $urandom_range(i == 0 ? 127 : 255, 0));
        end
        rdc('h28);
        wm('h04, ix);
    endtask
    task automatic launch(input int bad);
        wm('h18, 'h80);
        mdl['h18] = bad ? 'ha0 : 'h00;
        rdc('h18);
        if (!bad) `CHK("irq_busy", 0, irq)
        repeat (PC + 4) @(posedge clk);
        mdl['h18] = bad ? 'ha0 : 'h80;
        rdc('h18);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = $urandom(81204);
        mdl = '{'h04:0, 'h08:0, 'h10:0, 'h18:'h80, 'h1c:0, 'h20:'hff, 'h24:'hff, 'h28:0,
                'h2c:0, 'h30:0, 'h34:0, 'h38:0, 'h3c:0, 'h40:'hff, 'h44:0, 'h48:0, 'h4c:0};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        tag <= $urandom;
        @(posedge clk);
        mdl['h30] = tag[15:8];
        mdl['h34] = tag[7:0];
        foreach (mdl[a]) if (!(a inside {'h28, 'h2c, 'h38, 'h3c})) rdc(a);
        rdc('h3f0);
        wm('h3f0, 1);
        for (int i = 0; i < 4; i++) begin
            foreach (wa[j]) begin
                wm(wa[j], $urandom);
                rdc(wa[j]);
            end
            `CHK("irq", mdl['h10] >> 7, irq)
            `CHK("force_sf", mdl['h10] & 1, fs)
            `CHK("force_df", (mdl['h10] >> 1) & 1, fd)
        end
        wm('h08, 'hfd);
        rdc('h08);
        wm('h10, 'h80);
        wm('h1c, 3);
        pulse(1'b1, 1'b0);
        mdl['h1c] = 1;
        rdc('h1c);
        for (int k = 0; k < 8; k++) begin
            wm('h08, k);
            u_host.rd('h3c, ed, er);
            esum += ed;
        end
        `CHK("ecc_word", eccw[7:0], esum)
        wm('h1c, 1);
        rdc('h1c);
        wm('h10, 'h90);
        pulse(1'b1, 1'b1);
        mdl['h1c] = 2;
        rdc('h1c);
        wm('h1c, 3);
        load('h05, 5, 'h10);
        launch(0);
        `CHK("load_active", 1, lact)
        `CHK("irq_done", 1, irq)
        load('h05, 3, 'h18);
        launch(1);
        `CHK("load_active", 0, lact)
        wm('h18, 'h20);
        load('h05, 5, 'h13);
        launch(1);
        wm('h18, 'h20);
        load('h05, 5, 'h20);
        launch(0);
        load('h09, 0, 'h00);
        wm('h18, 'h80);
        repeat (PC + 4) @(posedge clk);
        `CHK("load_active", 0, lact)
        end_of_test();
    end
endmodule
